/* ppr_pkg.sv */
// package: selects, field positions, reset values and carrier types for the painting registers
package ppr_pkg;
    // register selects on the painting internal bus (source/destination code)
    localparam logic [4:0] SEL_VME_CTRL = 5'h00;
    localparam logic [4:0] SEL_VME_STAT = 5'h01;
    localparam logic [4:0] SEL_ADDR_HI = 5'h02;
    localparam logic [4:0] SEL_ADDR_LO = 5'h03;
    localparam logic [4:0] SEL_INT_ID = 5'h04;
    localparam logic [4:0] SEL_ROM_PTR = 5'h05;
    localparam logic [4:0] SEL_MUL_MODE = 5'h06;
    localparam logic [4:0] SEL_BITNUM = 5'h07;
    localparam logic [4:0] SEL_OUT_FLAGS = 5'h08;
    localparam logic [4:0] SEL_IN_FLAGS = 5'h09;
    localparam logic [4:0] SEL_LED_FLAGS = 5'h0A;
    localparam logic [4:0] SEL_BRANCH = 5'h0B;
    localparam logic [4:0] SEL_VME_DATA = 5'h0C;
    localparam logic [4:0] SEL_MUL_X = 5'h0D;
    localparam logic [4:0] SEL_MUL_Y = 5'h0E;
    localparam logic [4:0] SEL_MUL_RES = 5'h0F;
    // field positions
    localparam int CTRL_WIDTH_BIT = 0;
    localparam int STAT_PEND_BIT = 15;
    localparam int STAT_ILLACC_BIT = 4;
    localparam int STAT_AERR_BIT = 3;
    localparam int STAT_ATO_BIT = 2;
    localparam int STAT_ERR_BIT = 1;
    localparam int STAT_TO_BIT = 0;
    localparam int IN_FIFO_BIT = 10;
    localparam int IN_DIR_BIT = 9;
    // values after reset
    localparam logic [15:0] STAT_IDLE = 16'hFFFF;
    localparam logic [3:0] LED_RESET = 4'hF;
    localparam logic [15:0] IN_FIXED_ONES = 16'hF900;
    // transfer timeout
    localparam int CLK_MHZ = 100;
    localparam int TIMEOUT_US = 5;
    localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
    localparam int TMO_W = 10;
    // one master transfer request toward the bus
    typedef struct packed {
        logic [23:0] addr;
        logic [5:0] am;
        logic word;
        logic write;
        logic [15:0] data;
    } ppr_xfer_s;
    // error flags of one transfer, active high inside the block
    typedef struct packed {
        logic illacc;
        logic berr;
        logic tmo;
    } ppr_err_s;
    typedef enum logic [1:0] {XF_IDLE, XF_WAIT} ppr_xfer_e;
endpackage

/* ppr_regs.sv */
// painting processor internal register bank with bus master transfer control
`timescale 1ns/1ns
module ppr_regs
(
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic wr_i, // microcode write strobe, destination select valid
    input wire logic rd_i, // microcode read strobe, source select valid
    input wire logic [4:0] sel_i, // register select
    input wire logic [15:0] wdata_i,
    input wire logic cnt_up_i, // count address up by one
    input wire logic cnt_dn_i, // count address down by one
    input wire logic start_i, // start a bus transfer
    input wire logic start_write_i, // direction of started transfer
    input wire logic route_res_i, // result routed straight into an operand
    input wire logic bitnum_sel_i, // microcode picks bit-number override
    input wire logic [15:0] instr_i, // instruction word toward the alu slice
    input wire logic int_enable_i, // board interrupt enable
    input wire logic int_ack_i, // interrupt cycle accepted by handler
    input wire logic dtack_i, // bus data acknowledge (pin)
    input wire logic berr_i, // bus error acknowledge (pin)
    input wire logic [15:0] bus_rdata_i, // data returned by the bus slave
    input wire logic [31:0] product_i, // multiplier product
    input wire logic fifo_ready_i, // fifo has readable words
    input wire logic fifo_dir_i, // fifo direction, 1 painting to viewing
    input wire logic [7:0] peer_flags_i, // viewing processor flags
    output logic [15:0] rdata_o,
    output ppr_pkg::ppr_xfer_s xfer_o,
    output logic xfer_req_o,
    output logic irq_req_o, // interrupt cycle request
    output logic [7:0] irq_vector_o,
    output logic int_flag_o, // board interrupt flag
    output logic mul_signed_o,
    output logic [15:0] mul_x_o,
    output logic [15:0] mul_y_o,
    output logic [15:0] instr_o, // instruction with override applied
    output logic [7:0] out_flags_o,
    output logic [3:0] status_flags_o, // board status bits
    output logic [3:0] led_n_o, // lamp drive, low lights
    output logic [14:0] branch_o,
    output logic [15:0] rom_ptr_o
);
    // pin synchronisers: stage one feeds stage two only
    logic [1:0] sync1_ff;
    logic [1:0] sync2_ff;
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sync1_ff <= 2'h0;
            sync2_ff <= 2'h0;
        end
        else
        begin
            sync1_ff <= {berr_i, dtack_i};
            sync2_ff <= sync1_ff;
        end
    end
    wire logic dtack_s = sync2_ff[0];
    wire logic berr_s = sync2_ff[1];

    wire logic wr_hit_ctrl = wr_i && (sel_i == ppr_pkg::SEL_VME_CTRL);
    wire logic rd_stat = rd_i && (sel_i == ppr_pkg::SEL_VME_STAT);
    wire logic rd_res = rd_i && (sel_i == ppr_pkg::SEL_MUL_RES);
    wire logic ld_x = wr_i && (sel_i == ppr_pkg::SEL_MUL_X);
    wire logic ld_y = wr_i && (sel_i == ppr_pkg::SEL_MUL_Y);

    // configuration registers written by microcode
    logic [6:0] ctrl_ff, nxt_ctrl;
    logic [23:0] addr_ff, nxt_addr;
    logic [15:0] rom_ptr_ff, nxt_rom_ptr;
    logic mul_signed_ff, nxt_mul_signed;
    logic mpenbl_ff, nxt_mpenbl; // product-half enable, bit 1 of mode register
    logic [3:0] bitnum_ff, nxt_bitnum;
    logic [7:0] out_flags_ff, nxt_out_flags;
    logic [3:0] led_ff, nxt_led;
    logic [14:0] branch_ff, nxt_branch;
    logic [15:0] mul_x_ff, nxt_mul_x;
    logic [15:0] mul_y_ff, nxt_mul_y;
    logic mpsel_ff, nxt_mpsel; // product-half-select flip-flop

    // lower product half when select set, upper when clear
    wire logic [15:0] res_half = mpsel_ff ? product_i[15:0] : product_i[31:16];
    // routing into an operand follows the enable bit, not the flip-flop
    wire logic [15:0] route_half = mpenbl_ff ? product_i[15:0] : product_i[31:16];

    always_comb
    begin
        nxt_ctrl = ctrl_ff;
        nxt_addr = addr_ff;
        nxt_rom_ptr = rom_ptr_ff;
        nxt_mul_signed = mul_signed_ff;
        nxt_mpenbl = mpenbl_ff;
        nxt_bitnum = bitnum_ff;
        nxt_out_flags = out_flags_ff;
        nxt_led = led_ff;
        nxt_branch = branch_ff;
        nxt_mul_x = mul_x_ff;
        nxt_mul_y = mul_y_ff;
        nxt_mpsel = mpsel_ff;
        // write decode
        if (wr_i)
        begin
            unique case (sel_i)
                ppr_pkg::SEL_VME_CTRL: nxt_ctrl = wdata_i[6:0];
                ppr_pkg::SEL_ADDR_HI: nxt_addr[23:16] = wdata_i[7:0];
                ppr_pkg::SEL_ADDR_LO: nxt_addr[15:0] = wdata_i;
                ppr_pkg::SEL_ROM_PTR: nxt_rom_ptr = wdata_i;
                ppr_pkg::SEL_MUL_MODE:
                begin
                    nxt_mul_signed = wdata_i[0];
                    nxt_mpenbl = wdata_i[1];
                end
                ppr_pkg::SEL_BITNUM: nxt_bitnum = wdata_i[3:0];
                ppr_pkg::SEL_OUT_FLAGS: nxt_out_flags = wdata_i[7:0];
                ppr_pkg::SEL_LED_FLAGS: nxt_led = wdata_i[3:0];
                ppr_pkg::SEL_BRANCH: nxt_branch = wdata_i[14:0];
                ppr_pkg::SEL_MUL_X: nxt_mul_x = route_res_i ? route_half : wdata_i;
                ppr_pkg::SEL_MUL_Y: nxt_mul_y = route_res_i ? route_half : wdata_i;
                default: ;
            endcase
        end
        // counting; a write to either address half in the same cycle takes priority
        if (!(wr_i && (sel_i == ppr_pkg::SEL_ADDR_HI || sel_i == ppr_pkg::SEL_ADDR_LO)))
        begin
            if (cnt_up_i && !cnt_dn_i)
                nxt_addr = addr_ff + 24'h000001;
            else if (cnt_dn_i && !cnt_up_i)
                nxt_addr = addr_ff - 24'h000001;
        end
        // operand load loads the select from the enable; result reads toggle it
        if (ld_x || ld_y)
            nxt_mpsel = mpenbl_ff;
        else if (rd_res)
            nxt_mpsel = ~mpsel_ff;
    end

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ctrl_ff <= 7'h00;
            addr_ff <= 24'h000000;
            rom_ptr_ff <= 16'h0000;
            mul_signed_ff <= 1'b0;
            mpenbl_ff <= 1'b0;
            bitnum_ff <= 4'h0;
            out_flags_ff <= 8'h00;
            led_ff <= ppr_pkg::LED_RESET;
            branch_ff <= 15'h0000;
            mul_x_ff <= 16'h0000;
            mul_y_ff <= 16'h0000;
            mpsel_ff <= 1'b0;
        end
        else
        begin
            ctrl_ff <= nxt_ctrl;
            addr_ff <= nxt_addr;
            rom_ptr_ff <= nxt_rom_ptr;
            mul_signed_ff <= nxt_mul_signed;
            mpenbl_ff <= nxt_mpenbl;
            bitnum_ff <= nxt_bitnum;
            out_flags_ff <= nxt_out_flags;
            led_ff <= nxt_led;
            branch_ff <= nxt_branch;
            mul_x_ff <= nxt_mul_x;
            mul_y_ff <= nxt_mul_y;
            mpsel_ff <= nxt_mpsel;
        end
    end

    // bus transfer engine with error capture
    ppr_pkg::ppr_xfer_e xst_ff, nxt_xst;
    logic req_ff, nxt_req; // transfer open, its own flop so the pin needs no decode
    ppr_pkg::ppr_xfer_s xfer_ff, nxt_xfer;
    logic [ppr_pkg::TMO_W-1:0] tmo_ff, nxt_tmo;
    ppr_pkg::ppr_err_s last_ff, nxt_last; // last transfer errors, active high
    ppr_pkg::ppr_err_s acc_ff, nxt_acc; // accrued errors, active high
    logic [15:0] vdata_ff, nxt_vdata;

    always_comb
    begin
        nxt_xst = xst_ff;
        nxt_xfer = xfer_ff;
        nxt_tmo = tmo_ff;
        nxt_last = last_ff;
        nxt_acc = acc_ff;
        nxt_vdata = vdata_ff;
        if (wr_i && sel_i == ppr_pkg::SEL_VME_DATA)
            nxt_vdata = wdata_i;
        // clearing on read; an error landing this cycle still sets below
        if (rd_stat)
            nxt_acc = '0;
        unique case (xst_ff)
            ppr_pkg::XF_IDLE:
            begin
                if (start_i)
                begin
                    // odd word address runs as even, flagged illegal
                    nxt_xfer.addr = {addr_ff[23:1],
                        addr_ff[0] & ~ctrl_ff[ppr_pkg::CTRL_WIDTH_BIT]};
                    nxt_xfer.am = ctrl_ff[6:1];
                    nxt_xfer.word = ctrl_ff[ppr_pkg::CTRL_WIDTH_BIT];
                    nxt_xfer.write = start_write_i;
                    nxt_xfer.data = vdata_ff;
                    nxt_last.illacc = ctrl_ff[ppr_pkg::CTRL_WIDTH_BIT] & addr_ff[0];
                    nxt_last.berr = 1'b0;
                    nxt_last.tmo = 1'b0;
                    nxt_acc.illacc = nxt_acc.illacc | nxt_last.illacc;
                    nxt_tmo = '0;
                    nxt_xst = ppr_pkg::XF_WAIT;
                end
            end
            ppr_pkg::XF_WAIT:
            begin
                nxt_tmo = tmo_ff + 1'b1;
                if (berr_s)
                begin
                    nxt_last.berr = 1'b1;
                    nxt_acc.berr = 1'b1;
                    nxt_xst = ppr_pkg::XF_IDLE;
                end
                else if (dtack_s)
                begin
                    if (!xfer_ff.write)
                        nxt_vdata = bus_rdata_i;
                    nxt_xst = ppr_pkg::XF_IDLE;
                end
                else if (tmo_ff == ppr_pkg::TMO_W'(ppr_pkg::TIMEOUT_CYC - 1))
                begin
                    nxt_last.tmo = 1'b1;
                    nxt_acc.tmo = 1'b1;
                    nxt_xst = ppr_pkg::XF_IDLE;
                end
            end
        endcase
        // request pin follows the next state, so it rises with the wait state
        nxt_req = (nxt_xst == ppr_pkg::XF_WAIT);
    end

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            xst_ff <= ppr_pkg::XF_IDLE;
            req_ff <= 1'b0;
            xfer_ff <= '0;
            tmo_ff <= '0;
            last_ff <= '0;
            acc_ff <= '0;
            vdata_ff <= 16'h0000;
        end
        else
        begin
            xst_ff <= nxt_xst;
            req_ff <= nxt_req;
            xfer_ff <= nxt_xfer;
            tmo_ff <= nxt_tmo;
            last_ff <= nxt_last;
            acc_ff <= nxt_acc;
            vdata_ff <= nxt_vdata;
        end
    end

    // interrupt id: flag, pending and cycle request
    logic int_flag_ff, nxt_int_flag;
    logic irq_ff, nxt_irq;
    logic [7:0] vec_ff, nxt_vec;
    always_comb
    begin
        nxt_int_flag = int_flag_ff;
        nxt_irq = irq_ff;
        nxt_vec = vec_ff;
        // acknowledge ends the cycle; a fresh write wins over it
        if (int_ack_i)
        begin
            nxt_irq = 1'b0;
            nxt_int_flag = 1'b0;
        end
        if (wr_i && sel_i == ppr_pkg::SEL_INT_ID)
        begin
            nxt_vec = wdata_i[7:0];
            nxt_int_flag = 1'b1;
            nxt_irq = int_enable_i;
        end
    end
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            int_flag_ff <= 1'b0;
            irq_ff <= 1'b0;
            vec_ff <= 8'h00;
        end
        else
        begin
            int_flag_ff <= nxt_int_flag;
            irq_ff <= nxt_irq;
            vec_ff <= nxt_vec;
        end
    end

    // read mux and override, registered so every output is a flip-flop
    logic [15:0] rdata_ff, nxt_rdata;
    logic [15:0] instr_ff, nxt_instr;
    always_comb
    begin
        nxt_rdata = rdata_ff;
        if (rd_i)
        begin
            unique case (sel_i)
                ppr_pkg::SEL_VME_STAT:
                begin
                    // active low, unused bits one
                    nxt_rdata = ppr_pkg::STAT_IDLE;
                    nxt_rdata[ppr_pkg::STAT_PEND_BIT] = ~int_flag_ff;
                    nxt_rdata[ppr_pkg::STAT_ILLACC_BIT] = ~acc_ff.illacc;
                    nxt_rdata[ppr_pkg::STAT_AERR_BIT] = ~acc_ff.berr;
                    nxt_rdata[ppr_pkg::STAT_ATO_BIT] = ~acc_ff.tmo;
                    nxt_rdata[ppr_pkg::STAT_ERR_BIT] = ~last_ff.berr;
                    nxt_rdata[ppr_pkg::STAT_TO_BIT] = ~last_ff.tmo;
                end
                ppr_pkg::SEL_IN_FLAGS:
                begin
                    nxt_rdata = ppr_pkg::IN_FIXED_ONES | {8'h00, peer_flags_i};
                    nxt_rdata[ppr_pkg::IN_FIFO_BIT] = fifo_ready_i;
                    nxt_rdata[ppr_pkg::IN_DIR_BIT] = fifo_dir_i;
                end
                ppr_pkg::SEL_VME_DATA: nxt_rdata = vdata_ff;
                ppr_pkg::SEL_MUL_RES: nxt_rdata = res_half;
                default: nxt_rdata = 16'hFFFF;
            endcase
        end
        nxt_instr = instr_i;
        if (bitnum_sel_i)
            nxt_instr[12:9] = bitnum_ff;
    end
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rdata_ff <= 16'h0000;
            instr_ff <= 16'h0000;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
            instr_ff <= nxt_instr;
        end
    end

    assign rdata_o = rdata_ff;
    assign xfer_o = xfer_ff;
    assign xfer_req_o = req_ff;
    assign irq_req_o = irq_ff;
    assign irq_vector_o = vec_ff;
    assign int_flag_o = int_flag_ff;
    assign mul_signed_o = mul_signed_ff;
    assign mul_x_o = mul_x_ff;
    assign mul_y_o = mul_y_ff;
    assign instr_o = instr_ff;
    assign out_flags_o = out_flags_ff;
    assign status_flags_o = led_ff;
    assign led_n_o = led_ff;
    assign branch_o = branch_ff;
    assign rom_ptr_o = rom_ptr_ff;
endmodule // ppr_regs

/* ppr_props.sv */
// checker: port-level timing of the painting register bank
`timescale 1ns/1ns
module ppr_chk
(
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [4:0] sel_i,
    input wire logic [15:0] wdata_i,
    input wire logic start_i,
    input wire logic bitnum_sel_i,
    input wire logic [15:0] instr_i,
    input wire logic int_enable_i,
    input wire logic dtack_i,
    input wire logic fifo_ready_i,
    input wire logic fifo_dir_i,
    input wire logic [7:0] peer_flags_i,
    input wire logic [15:0] rdata_o,
    input wire ppr_pkg::ppr_xfer_s xfer_o,
    input wire logic xfer_req_o,
    input wire logic irq_req_o,
    input wire logic [7:0] irq_vector_o,
    input wire logic int_flag_o,
    input wire logic [15:0] instr_o,
    input wire logic [3:0] status_flags_o,
    input wire logic [3:0] led_n_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    // length of the open transfer, so a missing timeout cannot hide
    logic [9:0] wait_ff;
    logic [9:0] nxt_wait;
    always_comb nxt_wait = xfer_req_o ? wait_ff + 10'h001 : 10'h000;
    always_ff @(posedge clock_i or negedge rstn_i)
        if (!rstn_i)
            wait_ff <= 10'h000;
        else
            wait_ff <= nxt_wait;
    // register write and read with a given select
    sequence s_wr(logic [4:0] s);
        wr_i && sel_i == s;
    endsequence
    sequence s_rd(logic [4:0] s);
        rd_i && sel_i == s;
    endsequence
    property p_start;
        start_i && !xfer_req_o |=> xfer_req_o;
    endproperty
    a_start: assert property (p_start) else $error("transfer not started");
    property p_odd;
        xfer_req_o && xfer_o.word |-> !xfer_o.addr[0];
    endproperty
    a_odd: assert property (p_odd) else $error("odd word address on bus");
    property p_ack;
        xfer_req_o && dtack_i |-> ##[1:4] !xfer_req_o;
    endproperty
    a_ack: assert property (p_ack) else $error("acknowledge not ending transfer");
    property p_tmo;
        wait_ff <= 10'h1F9;
    endproperty
    a_tmo: assert property (p_tmo) else $error("transfer outlived timeout");
    property p_stat;
        s_rd(ppr_pkg::SEL_VME_STAT) |=> rdata_o[15:5] == {~$past(int_flag_o), 10'h3FF};
    endproperty
    a_stat: assert property (p_stat) else $error("status pending or spare bits");
    property p_in;
        s_rd(ppr_pkg::SEL_IN_FLAGS) |=> rdata_o == {5'h1F, $past(fifo_ready_i),
            $past(fifo_dir_i), 1'b1, $past(peer_flags_i)};
    endproperty
    a_in: assert property (p_in) else $error("incoming flags wrong");
    property p_int;
        s_wr(ppr_pkg::SEL_INT_ID) |=> int_flag_o && {8'h00, irq_vector_o} == ($past(wdata_i) & 16'h00FF);
    endproperty
    a_int: assert property (p_int) else $error("interrupt flag or vector");
    property p_irq;
        s_wr(ppr_pkg::SEL_INT_ID) ##0 int_enable_i |=> irq_req_o;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt cycle not requested");
    property p_nosel;
        !bitnum_sel_i |=> instr_o == $past(instr_i);
    endproperty
    a_nosel: assert property (p_nosel) else $error("instruction altered");
    property p_led;
        s_wr(ppr_pkg::SEL_LED_FLAGS) |=> led_n_o == $past(wdata_i[3:0]) && status_flags_o == led_n_o;
    endproperty
    a_led: assert property (p_led) else $error("lamps differ from status");
endmodule // ppr_chk

/* ppr_vme_slave.sv */
// far-side bus slave: answers with acknowledge, bus error or silence
`timescale 1ns/1ns
module ppr_vme_slave
(
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire ppr_pkg::ppr_xfer_s xfer_i,
    input wire logic req_i,
    input wire logic [1:0] mode_i, // 0 acknowledge, 1 bus error, 2 silent
    input wire logic [3:0] dly_i, // wait cycles before answering
    output logic dtack_o,
    output logic berr_o,
    output logic [15:0] rdata_o
);
    logic [3:0] cnt_ff; // cycles waited in this transfer
    logic ans_ff; // answer held until the request goes away
    // answer after the delay and keep it until the master lets go
    always_ff @(posedge clock_i or negedge rstn_i)
        if (!rstn_i || !req_i)
        begin
            cnt_ff <= 4'h0;
            ans_ff <= 1'b0;
        end
        else if (cnt_ff == dly_i && mode_i != 2'h2)
            ans_ff <= 1'b1;
        else if (cnt_ff != 4'hF)
            cnt_ff <= cnt_ff + 4'h1;
    assign dtack_o = ans_ff && mode_i == 2'h0;
    assign berr_o = ans_ff && mode_i == 2'h1;
    // data is valid only while answering; inverted otherwise so stale reads show
    assign rdata_o = ans_ff ? xfer_i.addr[15:0] ^ 16'h5A5A : ~(xfer_i.addr[15:0] ^ 16'h5A5A);
endmodule // ppr_vme_slave

/* tb.sv */
// testbench for the painting register bank
`timescale 1ns/1ns
module tb;
    logic clock_i, rstn_i, wr_i, rd_i, cnt_up_i, cnt_dn_i, start_i, start_write_i;
    logic route_res_i, bitnum_sel_i, int_enable_i, int_ack_i, dtack_i, berr_i;
    logic fifo_ready_i, fifo_dir_i, xfer_req_o, irq_req_o, int_flag_o, mul_signed_o;
    logic [4:0] sel_i;
    logic [15:0] wdata_i, bus_rdata_i, instr_i, rdata_o, mul_x_o, mul_y_o, instr_o, rom_ptr_o;
    logic [31:0] product_i;
    logic [7:0] peer_flags_i, irq_vector_o, out_flags_o;
    ppr_pkg::ppr_xfer_s xfer_o;
    logic [3:0] status_flags_o, led_n_o;
    logic [14:0] branch_o;
    logic [1:0] mode; // far-side answer kind
    logic [3:0] dly; // far-side answer delay
    logic [31:0] seed = 32'h151E;
    logic [23:0] adr; // expected counter value
    logic [15:0] c, d;
    logic ill, lb, lt; // expected illegal, last bus error, last timeout
    int error_cnt = 0;
    int tests_run = 0;
    ppr_regs dut (.*);
    ppr_vme_slave far (.clock_i, .rstn_i, .xfer_i(xfer_o), .req_i(xfer_req_o), .mode_i(mode),
        .dly_i(dly), .dtack_o(dtack_i), .berr_o(berr_i), .rdata_o(bus_rdata_i));
    initial
    begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // expected status word, accrued part present only when a is set
    function automatic logic [15:0] st(input logic p, i, b, t, a);
        return {~p, 10'h3FF, ~(i & a), ~(b & a), ~(t & a), ~b, ~t};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [4:0] s, input logic [15:0] v);
        @(posedge clock_i);
        #1;
        wr_i = 1'b1;
        sel_i = s;
        wdata_i = v;
        @(posedge clock_i);
        #1;
        wr_i = 1'b0;
    endtask
    task automatic rd(input logic [4:0] s, input logic [15:0] e);
        @(posedge clock_i);
        #1;
        rd_i = 1'b1;
        sel_i = s;
        @(posedge clock_i);
        #1;
        rd_i = 1'b0;
        chk(rdata_o, e);
    endtask
    // one master transfer; mode picks how the far side answers
    task automatic run(input logic w, input logic [1:0] m);
        mode = m;
        dly = 4'(rnd());
        ill = c[0] & adr[0];
        @(posedge clock_i);
        #1;
        start_i = 1'b1;
        start_write_i = w;
        @(posedge clock_i);
        #1;
        start_i = 1'b0;
        chk({xfer_req_o, xfer_o.write, xfer_o.am, xfer_o.word}, {1'b1, w, c[6:0]});
        chk(xfer_o.addr, {adr[23:1], adr[0] & ~c[0]});
        for (int i = 0; i < 700 && xfer_req_o; i++) #10;
        repeat (2) @(posedge clock_i);
        #1;
        lb = m == 2'h1;
        lt = m == 2'h2;
        rd(ppr_pkg::SEL_VME_STAT, st(1'b0, ill, lb, lt, 1'b1));
        rd(ppr_pkg::SEL_VME_STAT, st(1'b0, ill, lb, lt, 1'b0));
        if (!w && m == 2'h0)
            rd(ppr_pkg::SEL_VME_DATA, xfer_o.addr[15:0] ^ 16'h5A5A);
    endtask
    task automatic conclude();
        if (error_cnt == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        #200000;
        error_cnt++;
        conclude();
    end
    initial
    begin
        {rstn_i, wr_i, rd_i, cnt_up_i, cnt_dn_i, start_i, start_write_i, route_res_i} = 8'h00;
        {bitnum_sel_i, int_enable_i, int_ack_i, fifo_ready_i, fifo_dir_i} = 5'h00;
        {sel_i, wdata_i, instr_i, product_i, peer_flags_i, mode, dly} = 0;
        repeat (6) @(posedge clock_i);
        #1;
        rstn_i = 1'b1;
        rd(ppr_pkg::SEL_VME_STAT, 16'hFFFF);
        rd(5'h1F, 16'hFFFF);
        for (int k = 0; k < 12; k++)
        begin
            c = 16'(rnd());
            adr = k < 2 ? (k ? 24'h130000 : 24'h12FFFF) : 24'(rnd());
            wr(ppr_pkg::SEL_VME_CTRL, c);
            wr(ppr_pkg::SEL_ADDR_HI, {8'(rnd()), adr[23:16]});
            wr(ppr_pkg::SEL_ADDR_LO, adr[15:0]);
            if (k < 4)
            begin
                cnt_up_i = !k[0];
                cnt_dn_i = k[0];
                @(posedge clock_i);
                #1;
                {cnt_up_i, cnt_dn_i} = 2'h0;
                adr = k[0] ? adr - 24'h1 : adr + 24'h1;
            end
            run(rnd() % 2, 2'(k % 3));
        end
        for (int k = 0; k < 2; k++)
        begin
            int_enable_i = k[0];
            d = 16'(rnd());
            wr(ppr_pkg::SEL_INT_ID, d);
            chk({int_flag_o, irq_req_o, irq_vector_o}, {1'b1, k[0], d[7:0]});
            rd(ppr_pkg::SEL_VME_STAT, st(1'b1, 1'b0, lb, lt, 1'b0));
            int_ack_i = 1'b1;
            @(posedge clock_i);
            #1;
            int_ack_i = 1'b0;
            rd(ppr_pkg::SEL_VME_STAT, st(1'b0, 1'b0, lb, lt, 1'b0));
        end
        for (int k = 0; k < 8; k++)
        begin
            wr(ppr_pkg::SEL_MUL_MODE, {14'(rnd()), k[1:0]});
            chk(mul_signed_o, k[0]);
            product_i = rnd();
            route_res_i = k[2];
            d = 16'(rnd());
            wr(k[0] ? ppr_pkg::SEL_MUL_Y : ppr_pkg::SEL_MUL_X, d);
            route_res_i = 1'b0;
            c = k[1] ? product_i[15:0] : product_i[31:16]; // half picked by enable
            chk(k[0] ? mul_y_o : mul_x_o, k[2] ? c : d);
            repeat (2) @(posedge clock_i);
            rd(ppr_pkg::SEL_MUL_RES, k[1] ? product_i[15:0] : product_i[31:16]);
            rd(ppr_pkg::SEL_MUL_RES, k[1] ? product_i[31:16] : product_i[15:0]);
        end
        for (int k = 0; k < 6; k++)
        begin
            d = 16'(rnd());
            wr(ppr_pkg::SEL_BITNUM, d);
            instr_i = 16'(rnd());
            bitnum_sel_i = k[0];
            @(posedge clock_i);
            #1;
            chk(instr_o, k[0] ? {instr_i[15:13], d[3:0], instr_i[8:0]} : instr_i);
            wr(ppr_pkg::SEL_OUT_FLAGS, d);
            chk(out_flags_o, d[7:0]);
            wr(ppr_pkg::SEL_LED_FLAGS, d);
            chk({status_flags_o, led_n_o}, {2{d[3:0]}});
            wr(ppr_pkg::SEL_BRANCH, d);
            wr(ppr_pkg::SEL_ROM_PTR, d);
            chk({branch_o, rom_ptr_o}, {d[14:0], d});
            {fifo_ready_i, fifo_dir_i, peer_flags_i} = 10'(rnd());
            rd(ppr_pkg::SEL_IN_FLAGS, {5'h1F, fifo_ready_i, fifo_dir_i, 1'b1, peer_flags_i});
        end
        conclude();
    end
endmodule // tb
bind ppr_regs ppr_chk chk_i (.*);
